/* src/ngeiu_regs.svh */
`ifndef NGEIU_REGS_SVH
`define NGEIU_REGS_SVH

// apb byte addresses
`define NGEIU_CTRL_OFS       8'h00
`define NGEIU_STAT_OFS       8'h04
`define NGEIU_IFLAG_OFS      8'h08
`define NGEIU_IEN_OFS        8'h0C
`define NGEIU_ERRINFO_OFS    8'h10
`define NGEIU_FIRST_OFS      8'h14
`define NGEIU_LAST_OFS       8'h18
`define NGEIU_DEVCFG_OFS     8'h1C

// control register
`define NGEIU_CTRL_WP_BIT    3
`define NGEIU_CTRL_RST       8'h00

// status register
`define NGEIU_STAT_RUN_BIT   0
`define NGEIU_STAT_CD_BIT    1
`define NGEIU_STAT_LCK_BIT   2
`define NGEIU_STAT_WP_BIT    3

// flag and enable bit positions
`define NGEIU_IRQ_HALT       0
`define NGEIU_IRQ_ECCERR     1
`define NGEIU_IRQ_ECCRDY     2
`define NGEIU_IRQ_ILGL       3
`define NGEIU_IRQ_CARD       4
`define NGEIU_IEN_GLOBAL_BIT 5
`define NGEIU_IRQ_NUM        5

// device config register fields
`define NGEIU_DEV_MASK_LSB   0
`define NGEIU_DEV_CARD_BIT   4
`define NGEIU_DEV_CNT_LSB    8

// ecc identification codes and descriptor
`define NGEIU_ECC_CORR       2'h1
`define NGEIU_ECC_UNCORR     2'h2
`define NGEIU_ECC_BADECC     2'h3
`define NGEIU_DESC_BYTES     4

`endif

/* src/ngeiu_pkg.sv */
`default_nettype none
package ngeiu_pkg;
    typedef logic [1:0]  ngeiu_ecc_code_t;
    typedef logic [2:0]  ngeiu_bit_idx_t;
    typedef logic [7:0]  ngeiu_byte_t;
    typedef logic [1:0]  ngeiu_dev_t;
    typedef logic [3:0]  ngeiu_dev_mask_t;
    typedef logic [15:0] ngeiu_block_t;
endpackage
`default_nettype wire

/* src/ngeiu_range_check.sv */
`default_nettype none
module ngeiu_range_check
    import ngeiu_pkg::*;
#(
    parameter int NDEV = 4
) (
    // protected range
    input  wire ngeiu_pkg::ngeiu_block_t    i_first_locked_block,
    input  wire ngeiu_pkg::ngeiu_block_t    i_last_locked_block,
    input  wire ngeiu_pkg::ngeiu_dev_mask_t i_locked_device_mask,
    // request under test
    input  wire ngeiu_pkg::ngeiu_dev_t      i_target_device_index,
    input  wire ngeiu_pkg::ngeiu_block_t    i_block,
    // result
    output logic                            o_hit
);
    // bit 3 covers device 3 or the card alike; the card-mode choice only
    // renames the target, so the mask lookup is the same in both modes
    logic [NDEV-1:0] dev_sel;
    wire             in_order  = i_first_locked_block < i_last_locked_block;
    wire             in_equal  = i_first_locked_block == i_last_locked_block;
    wire             in_fwd    = (i_block >= i_first_locked_block) &&
                                 (i_block <= i_last_locked_block);
    wire             in_wrap   = (i_block < i_last_locked_block) ||
                                 (i_block > i_first_locked_block);
    wire             in_range  = in_equal ? 1'b1 :
                                 in_order ? in_fwd :
                                            in_wrap;

    genvar g;
    generate
        for (g = 0; g < NDEV; g++) begin : g_dev
            assign dev_sel[g] = i_locked_device_mask[g] &&
                                (i_target_device_index == g);
        end
    endgenerate

    assign o_hit = (|dev_sel) && in_range;
endmodule
`default_nettype wire

/* src/ngeiu_top.sv */
// Our own choices: the register offsets and the APB interface to the registers.
`include "ngeiu_regs.svh"
`default_nettype none
module ngeiu_top
    import ngeiu_pkg::*;
#(
    parameter int NDEV = 4
) (
    // clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rstn,
    // apb slave
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [7:0]                i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output logic [31:0]                    o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    // system protection events, one-cycle pulses
    input  wire logic                      i_brownout_evt,
    input  wire logic                      i_ext_reset_evt,
    input  wire logic                      i_wdt_reset_evt,
    // program or erase request from the sequencer
    input  wire logic                      i_prog_req,
    input  wire ngeiu_pkg::ngeiu_dev_t     i_prog_dev,
    input  wire ngeiu_pkg::ngeiu_block_t   i_prog_block,
    output logic                           o_prog_grant,
    output logic                           o_prog_refused,
    // device access and register-write events
    input  wire logic                      i_access_req,
    input  wire logic [2:0]                i_target_device_index,
    input  wire logic                      i_event_reg_wr,
    input  wire logic                      i_action_reg_wr,
    // run control
    input  wire logic                      i_run_start,
    input  wire logic                      i_run_end,
    output logic                           o_running_status,
    // ecc engine
    input  wire logic                      i_ecc_ready,
    input  wire logic                      i_ecc_err,
    input  wire ngeiu_pkg::ngeiu_ecc_code_t i_first_half_error_code,
    input  wire ngeiu_pkg::ngeiu_ecc_code_t i_second_half_error_code,
    input  wire logic [15:0]               i_err_byte_pos,
    input  wire ngeiu_pkg::ngeiu_bit_idx_t i_first_half_fail_bit,
    input  wire ngeiu_pkg::ngeiu_bit_idx_t i_second_half_fail_bit,
    // card socket pins
    input  wire logic                      i_card_detect_in,
    input  wire logic                      i_card_lock_in,
    // nand side
    output logic                           o_mem_write_protect_n,
    output logic                           o_irq
);
    import ngeiu_pkg::*;

    localparam int NF = `NGEIU_IRQ_NUM;

    // register state
    logic [7:0]            controller_control_reg_ff;
    logic [NF-1:0]         irq_flag_reg_ff;
    logic [NF:0]           irq_enable_reg_ff;
    ngeiu_block_t          first_locked_block_ff;
    ngeiu_block_t          last_locked_block_ff;
    ngeiu_dev_mask_t       locked_device_mask_ff;
    logic                  card_mode_enable_ff;
    logic [2:0]            declared_device_count_ff;
    ngeiu_byte_t           desc_ff [`NGEIU_DESC_BYTES];
    logic [1:0]            rd_ptr_ff;
    logic                  running_ff;
    logic                  irq_ff;
    logic                  grant_ff;
    logic                  refused_ff;
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic [2:0]            cd_sync_ff;
    logic [1:0]            lck_sync_ff;

    // apb decode
    wire        acc_phase = i_psel && i_penable;
    wire        commit    = acc_phase && pready_ff;
    wire        wr_commit = commit && i_pwrite;
    wire        rd_commit = commit && !i_pwrite;
    wire        sel_ctrl  = i_paddr == `NGEIU_CTRL_OFS;
    wire        sel_stat  = i_paddr == `NGEIU_STAT_OFS;
    wire        sel_iflag = i_paddr == `NGEIU_IFLAG_OFS;
    wire        sel_ien   = i_paddr == `NGEIU_IEN_OFS;
    wire        sel_err   = i_paddr == `NGEIU_ERRINFO_OFS;
    wire        sel_first = i_paddr == `NGEIU_FIRST_OFS;
    wire        sel_last  = i_paddr == `NGEIU_LAST_OFS;
    wire        sel_dev   = i_paddr == `NGEIU_DEVCFG_OFS;
    wire        mapped    = sel_ctrl | sel_stat | sel_iflag | sel_ien |
                            sel_err | sel_first | sel_last | sel_dev;

    // card socket levels, synchronised
    wire        card_detect_status = cd_sync_ff[1];
    wire        card_lock_status   = lck_sync_ff[1];
    wire        card_edge = card_mode_enable_ff &&
                            (cd_sync_ff[1] != cd_sync_ff[2]);

    // protection check
    logic       range_hit;
    ngeiu_range_check #(
        .NDEV                 (NDEV)
    ) u_range (
        .i_first_locked_block (first_locked_block_ff),
        .i_last_locked_block  (last_locked_block_ff),
        .i_locked_device_mask (locked_device_mask_ff),
        .i_target_device_index(i_prog_dev),
        .i_block              (i_prog_block),
        .o_hit                (range_hit)
    );
    wire        prot_violation = i_prog_req && range_hit;
    wire        wp_force = i_brownout_evt | i_ext_reset_evt |
                           i_wdt_reset_evt | prot_violation;
    // an asserted protect pin also refuses the request at the source
    wire        wp_active   = !controller_control_reg_ff[`NGEIU_CTRL_WP_BIT];
    wire        prog_ok     = i_prog_req && !prot_violation && !wp_active;
    wire        prog_no     = i_prog_req && !prog_ok;

    // run state and interrupt sources
    wire        undeclared  = i_access_req &&
                    (i_target_device_index >= declared_device_count_ff);
    // action register writes are legal while running
    wire        bad_wr      = i_event_reg_wr && running_ff;
    wire        ecc_uncorr  =
                    (i_first_half_error_code == `NGEIU_ECC_UNCORR) ||
                    (i_second_half_error_code == `NGEIU_ECC_UNCORR);
    logic [NF-1:0] nxt_irq_flag;
    wire           run_after_cmd = (running_ff | i_run_start) && !i_run_end;
    wire [NF-1:1]  src_evt = {card_edge, undeclared | bad_wr,
                              i_ecc_ready, i_ecc_err};
    wire           trig = irq_enable_reg_ff[`NGEIU_IEN_GLOBAL_BIT] &&
                          |(src_evt & irq_enable_reg_ff[NF-1:1]);
    wire           nxt_running = run_after_cmd && !trig;
    // a trigger that stops the run sets halt too
    wire [NF-1:0]  set_evt = {src_evt, running_ff && !nxt_running};

    wire [NF-1:0] w1c = (wr_commit && sel_iflag) ?
                        i_pwdata[NF-1:0] : '0;
    // set beats a same-cycle clear
    assign nxt_irq_flag = (irq_flag_reg_ff & ~w1c) | set_evt;
    wire   nxt_irq = irq_enable_reg_ff[`NGEIU_IEN_GLOBAL_BIT] &&
                     |(nxt_irq_flag & irq_enable_reg_ff[NF-1:0]);

    // control register next value
    logic [7:0] nxt_ctrl;
    always_comb begin
        nxt_ctrl = controller_control_reg_ff;
        if (wr_commit && sel_ctrl) begin
            nxt_ctrl = i_pwdata[7:0];
        end
        if (wp_force) begin
            nxt_ctrl[`NGEIU_CTRL_WP_BIT] = 1'b0;
        end
    end

    // descriptor built from the ecc engine result
    wire [7:0] id_byte  = {4'h0, i_second_half_error_code,
                           i_first_half_error_code};
    wire [7:0] bit_byte = {2'b00, i_second_half_fail_bit,
                           i_first_half_fail_bit};
    wire [7:0] d1 = ecc_uncorr ? 8'h00 : i_err_byte_pos[15:8];
    wire [7:0] d2 = ecc_uncorr ? 8'h00 : i_err_byte_pos[7:0];
    wire [7:0] d3 = ecc_uncorr ? 8'h00 : bit_byte;
    wire       err_pop = rd_commit && sel_err;

    // status register view
    wire [31:0] stat_word = {28'h0,
                             !o_mem_write_protect_n,
                             card_lock_status,
                             card_detect_status,
                             running_ff};

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (1'b1)
            sel_ctrl:  rd_mux = {27'h0, controller_control_reg_ff[4:0]};
            sel_stat:  rd_mux = stat_word;
            sel_iflag: rd_mux = {27'h0, irq_flag_reg_ff};
            sel_ien:   rd_mux = {26'h0, irq_enable_reg_ff};
            sel_err:   rd_mux = {24'h0, desc_ff[rd_ptr_ff]};
            sel_first: rd_mux = {16'h0, first_locked_block_ff};
            sel_last:  rd_mux = {16'h0, last_locked_block_ff};
            sel_dev:   rd_mux = {21'h0, declared_device_count_ff,
                                 3'h0, card_mode_enable_ff,
                                 locked_device_mask_ff};
            default:   rd_mux = 32'h0;
        endcase
    end

    // apb answer: one wait state, data registered
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= acc_phase && !pready_ff;
            pslverr_ff <= acc_phase && !pready_ff && !mapped;
            prdata_ff  <= (acc_phase && !pready_ff && !i_pwrite) ?
                          rd_mux : 32'h0;
        end
    end

    // control, enables and protection config
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            controller_control_reg_ff <= `NGEIU_CTRL_RST;
            irq_enable_reg_ff         <= '0;
            first_locked_block_ff     <= 16'h0000;
            last_locked_block_ff      <= 16'h0000;
            locked_device_mask_ff     <= 4'h0;
            card_mode_enable_ff       <= 1'b0;
            declared_device_count_ff  <= 3'h0;
        end else begin
            controller_control_reg_ff <= {3'b000, nxt_ctrl[4:0]};
            if (wr_commit && sel_ien) begin
                irq_enable_reg_ff <= i_pwdata[NF:0];
            end
            if (wr_commit && sel_first) begin
                first_locked_block_ff <= i_pwdata[15:0];
            end
            if (wr_commit && sel_last) begin
                last_locked_block_ff <= i_pwdata[15:0];
            end
            if (wr_commit && sel_dev) begin
                locked_device_mask_ff    <= i_pwdata[3:0];
                card_mode_enable_ff      <= i_pwdata[`NGEIU_DEV_CARD_BIT];
                declared_device_count_ff <= i_pwdata[10:8];
            end
        end
    end

    // flags, run state and outputs
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            irq_flag_reg_ff       <= '0;
            running_ff            <= 1'b0;
            irq_ff                <= 1'b0;
            grant_ff              <= 1'b0;
            refused_ff            <= 1'b0;
            o_mem_write_protect_n <= 1'b0;
        end else begin
            irq_flag_reg_ff       <= nxt_irq_flag;
            running_ff            <= nxt_running;
            irq_ff                <= nxt_irq;
            grant_ff              <= prog_ok;
            refused_ff            <= prog_no;
            o_mem_write_protect_n <= nxt_ctrl[`NGEIU_CTRL_WP_BIT];
        end
    end

    // error descriptor and its read pointer
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            rd_ptr_ff <= 2'h0;
            for (int i = 0; i < `NGEIU_DESC_BYTES; i++) begin
                desc_ff[i] <= 8'h00;
            end
        end else if (i_ecc_err) begin
            desc_ff[0] <= id_byte;
            desc_ff[1] <= d1;
            desc_ff[2] <= d2;
            desc_ff[3] <= d3;
            rd_ptr_ff  <= 2'h0;
        end else if (err_pop) begin
            rd_ptr_ff  <= rd_ptr_ff + 2'h1;
        end
    end

    // socket pin synchronisers; stage 0 feeds stage 1 only
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            cd_sync_ff  <= 3'b111;
            lck_sync_ff <= 2'b11;
        end else begin
            cd_sync_ff  <= {cd_sync_ff[1:0], i_card_detect_in};
            lck_sync_ff <= {lck_sync_ff[0], i_card_lock_in};
        end
    end

    assign o_prdata         = prdata_ff;
    assign o_pready         = pready_ff;
    assign o_pslverr        = pslverr_ff;
    assign o_prog_grant     = grant_ff;
    assign o_prog_refused   = refused_ff;
    assign o_running_status = running_ff;
    assign o_irq            = irq_ff;

    // unused in this block: action writes never raise an illegal flag
    wire unused_ok = i_action_reg_wr;
endmodule
`default_nettype wire

/* verif/ngeiu_asserts.sv */
`include "ngeiu_regs.svh"
`default_nettype none
module ngeiu_asserts (
    // clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_rstn,
    // apb
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // protection
    input wire logic        i_brownout_evt,
    input wire logic        i_ext_reset_evt,
    input wire logic        i_wdt_reset_evt,
    input wire logic        i_prog_req,
    input wire logic        o_prog_grant,
    input wire logic        o_prog_refused,
    input wire logic        o_mem_write_protect_n
);
    timeunit 1ns;
    timeprecision 1ps;
    wire force_evt = i_brownout_evt | i_ext_reset_evt | i_wdt_reset_evt;
    wire stat_rd = o_pready & ~i_pwrite & (i_paddr == `NGEIU_STAT_OFS);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_setup; i_psel && !i_penable; endsequence
    sequence s_access; i_psel && i_penable; endsequence
    property p_apb_wait; s_setup ##1 s_access |=> o_pready; endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("no pready after wait");
    property p_rdy_pulse; o_pready |=> !o_pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("pready too long");
    property p_err_rdy; o_pslverr |-> o_pready; endproperty
    a_err_rdy: assert property (p_err_rdy)
        else $error("pslverr without pready");
    property p_rd_idle; !o_pready |-> o_prdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("stray read data");
    property p_rst_wp; $rose(i_rstn) |-> !o_mem_write_protect_n; endproperty
    a_rst_wp: assert property (p_rst_wp)
        else $error("no protect at reset");
    property p_force_wp; force_evt |=> !o_mem_write_protect_n; endproperty
    a_force_wp: assert property (p_force_wp)
        else $error("no forced protect");
    property p_prog_ans; i_prog_req |=> o_prog_grant != o_prog_refused;
    endproperty
    a_prog_ans: assert property (p_prog_ans)
        else $error("request not answered");
    property p_prog_wp;
        i_prog_req && !o_mem_write_protect_n |=> o_prog_refused;
    endproperty
    a_prog_wp: assert property (p_prog_wp)
        else $error("grant while protected");
    property p_ref_wp; o_prog_refused |-> ##[0:1] !o_mem_write_protect_n;
    endproperty
    a_ref_wp: assert property (p_ref_wp)
        else $error("refusal left protect off");
    property p_stat_wp;
        stat_rd |-> o_prdata[`NGEIU_STAT_WP_BIT] == !o_mem_write_protect_n;
    endproperty
    a_stat_wp: assert property (p_stat_wp)
        else $error("bad status protect");
endmodule
bind ngeiu_top ngeiu_asserts i_ngeiu_asserts (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_brownout_evt(i_brownout_evt), .i_ext_reset_evt(i_ext_reset_evt),
    .i_wdt_reset_evt(i_wdt_reset_evt), .i_prog_req(i_prog_req),
    .o_prog_grant(o_prog_grant), .o_prog_refused(o_prog_refused),
    .o_mem_write_protect_n(o_mem_write_protect_n));
`default_nettype wire

/* verif/ngeiu_socket_model.sv */
`default_nettype none
module ngeiu_socket_model (
    // socket state
    input  wire logic i_card_present,
    input  wire logic i_lock_closed,
    // socket pins
    output logic      o_card_detect_in,
    output logic      o_card_lock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up gives high with no card, a card grounds it
    assign o_card_detect_in = !i_card_present;
    // lock line only means something with a card seated
    assign o_card_lock_in = i_card_present ? !i_lock_closed : 1'b1;
endmodule
`default_nettype wire

/* verif/test_nand_guard_error_irq_unit.sv */
`include "ngeiu_regs.svh"
`default_nettype none
module test_nand_guard_error_irq_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import ngeiu_pkg::*;
    typedef struct packed {
        ngeiu_block_t first, last;
        ngeiu_dev_mask_t mask;
        logic card;
        ngeiu_dev_t dev;
        ngeiu_block_t blk;
        logic lk;
    } ngeiu_row_t;
    localparam int P_PROG = 3, P_ACC = 4, P_EV = 5, P_ACT = 6;
    localparam int P_RUN = 7, P_ERDY = 8, P_EERR = 9, P_END = 10;
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd;
    logic [10:0]  pls = 11'h000;
    ngeiu_dev_t   prog_dev = 2'h0;
    ngeiu_block_t prog_blk = 16'h0000;
    logic [2:0]   acc_idx = 3'h0;
    logic [25:0]  ecc_in = 26'h0;
    logic         card_in = 1'b0, lock_sw = 1'b0;
    logic         pready, pslverr, se, grant, refused;
    logic         running, cd, lck, wp_n, irq;
    int           err_total = 0;
    int           samples_checked = 0;
    ngeiu_row_t rows [14] = '{
        '{16'h0, 16'h0, 4'h1, 1'h0, 2'h0, 16'h4D2, 1'h1},
        '{16'h0, 16'h0, 4'h0, 1'h0, 2'h0, 16'h5, 1'h0},
        '{16'h0, 16'h0, 4'h2, 1'h0, 2'h1, 16'h5, 1'h1},
        '{16'h0, 16'h0, 4'h2, 1'h0, 2'h0, 16'h5, 1'h0},
        '{16'h0, 16'h0, 4'h4, 1'h0, 2'h2, 16'h9, 1'h1},
        '{16'h0, 16'h0, 4'h8, 1'h0, 2'h3, 16'h5, 1'h1},
        '{16'h0, 16'h0, 4'h8, 1'h1, 2'h3, 16'h5, 1'h1},
        '{16'hA, 16'h14, 4'h1, 1'h0, 2'h0, 16'hA, 1'h1},
        '{16'hA, 16'h14, 4'h1, 1'h0, 2'h0, 16'h14, 1'h1},
        '{16'hA, 16'h14, 4'h1, 1'h0, 2'h0, 16'h15, 1'h0},
        '{16'hA, 16'h14, 4'h1, 1'h0, 2'h0, 16'h9, 1'h0},
        '{16'h14, 16'hA, 4'h1, 1'h0, 2'h0, 16'h5, 1'h1},
        '{16'h14, 16'hA, 4'h1, 1'h0, 2'h0, 16'h19, 1'h1},
        '{16'h14, 16'hA, 4'h1, 1'h0, 2'h0, 16'hF, 1'h0}};
    logic [25:0] ecc_src [3] = '{{2'h1, 2'h1, 16'h0781, 3'h6, 3'h5},
        {2'h2, 2'h1, 16'h1234, 3'h1, 3'h2}, {2'h1, 2'h3, 16'h00FF, 3'h7, 3'h0}};
    logic [31:0] ecc_exp [3] = '{32'h0507812E, 32'h06000000, 32'h0D00FF07};
    ngeiu_top #(.NDEV(4)) i_ngeiu_top (
        .i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_brownout_evt(pls[0]), .i_ext_reset_evt(pls[1]),
        .i_wdt_reset_evt(pls[2]), .i_prog_req(pls[P_PROG]),
        .i_prog_dev(prog_dev), .i_prog_block(prog_blk),
        .o_prog_grant(grant), .o_prog_refused(refused),
        .i_access_req(pls[P_ACC]), .i_target_device_index(acc_idx),
        .i_event_reg_wr(pls[P_EV]), .i_action_reg_wr(pls[P_ACT]),
        .i_run_start(pls[P_RUN]), .i_run_end(pls[P_END]),
        .o_running_status(running), .i_ecc_ready(pls[P_ERDY]),
        .i_ecc_err(pls[P_EERR]), .i_first_half_error_code(ecc_in[25:24]),
        .i_second_half_error_code(ecc_in[23:22]),
        .i_err_byte_pos(ecc_in[21:6]), .i_first_half_fail_bit(ecc_in[5:3]),
        .i_second_half_fail_bit(ecc_in[2:0]), .i_card_detect_in(cd),
        .i_card_lock_in(lck), .o_mem_write_protect_n(wp_n), .o_irq(irq));
    ngeiu_socket_model i_ngeiu_socket_model (.i_card_present(card_in),
        .i_lock_closed(lock_sw), .o_card_detect_in(cd), .o_card_lock_in(lck));
    always #5 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) err_total++;
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e,
                         input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask
    task automatic pulse(input int k);
        pls[k] <= 1'b1;
        @(posedge clk);
        pls <= '0;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        #500000;
        err_total++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("wp_n reset", 32'(wp_n), 32'h0);
        rdchk(`NGEIU_CTRL_OFS, 32'hFF, 32'h0, "ctrl");
        rdchk(`NGEIU_STAT_OFS, 32'h08, 32'h08, "stat wp");
        rdchk(`NGEIU_LAST_OFS, 32'hFFFF, 32'h0, "last");
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'(se), 32'h1);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(`NGEIU_FIRST_OFS, 32'(rows[i].first));
            wr(`NGEIU_LAST_OFS, 32'(rows[i].last));
            wr(`NGEIU_DEVCFG_OFS, {21'h0, 3'h4, 3'h0, rows[i].card,
                                   rows[i].mask});
            wr(`NGEIU_CTRL_OFS, 32'h08);
            repeat (2) @(posedge clk);
            chk("wp_n open", 32'(wp_n), 32'h1);
            prog_dev <= rows[i].dev;
            prog_blk <= rows[i].blk;
            pls[P_PROG] <= 1'b1;
            @(posedge clk);
            pls <= '0;
            @(posedge clk);
            chk("refused", 32'(refused), 32'(rows[i].lk));
            chk("grant", 32'(grant), 32'(!rows[i].lk));
            repeat (2) @(posedge clk);
            chk("wp_n hit", 32'(wp_n), 32'(!rows[i].lk));
        end
        $display("test range done");
        for (int k = 0; k < 3; k++) begin
            wr(`NGEIU_CTRL_OFS, 32'h08);
            pulse(k);
            chk("wp_n forced", 32'(wp_n), 32'h0);
            rdchk(`NGEIU_CTRL_OFS, 32'h08, 32'h0, "ctrl forced");
        end
        wr(`NGEIU_CTRL_OFS, 32'h08);
        repeat (2) @(posedge clk);
        chk("wp_n set", 32'(wp_n), 32'h1);
        wr(`NGEIU_CTRL_OFS, 32'h00);
        repeat (2) @(posedge clk);
        chk("wp_n user", 32'(wp_n), 32'h0);
        $display("test protect done");
        pulse(P_RUN);
        rdchk(`NGEIU_STAT_OFS, 32'h01, 32'h01, "running");
        pulse(P_END);
        rdchk(`NGEIU_IFLAG_OFS, 32'h01, 32'h01, "halt");
        pulse(P_RUN);
        acc_idx <= 3'h3;
        pulse(P_ACC);
        pulse(P_ACT);
        rdchk(`NGEIU_IFLAG_OFS, 32'h08, 32'h0, "legal");
        pulse(P_EV);
        rdchk(`NGEIU_IFLAG_OFS, 32'h08, 32'h08, "illegal wr");
        wr(`NGEIU_IFLAG_OFS, 32'h1F);
        wr(`NGEIU_IEN_OFS, 32'h28);
        acc_idx <= 3'h4;
        pulse(P_ACC);
        chk("running", 32'(running), 32'h0);
        chk("irq", 32'(irq), 32'h1);
        rdchk(`NGEIU_IFLAG_OFS, 32'h1F, 32'h09, "illegal idx");
        wr(`NGEIU_IFLAG_OFS, 32'h1F);
        $display("test run done");
        wr(`NGEIU_IEN_OFS, 32'h22);
        foreach (ecc_exp[e]) begin
            ecc_in <= ecc_src[e];
            pulse(P_EERR);
            chk("irq ecc", 32'(irq), 32'h1);
            for (int b = 0; b < 5; b++) begin
                rdchk(`NGEIU_ERRINFO_OFS, 32'hFF,
                      32'(ecc_exp[e][31 - 8 * (b % 4) -: 8]), "err byte");
            end
            rdchk(`NGEIU_IFLAG_OFS, 32'h02, 32'h02, "ecc flag");
            wr(`NGEIU_IFLAG_OFS, 32'h02);
            rdchk(`NGEIU_IFLAG_OFS, 32'h02, 32'h0, "ecc clear");
            chk("irq clear", 32'(irq), 32'h0);
        end
        wr(`NGEIU_IEN_OFS, 32'h04);
        pulse(P_ERDY);
        rdchk(`NGEIU_IFLAG_OFS, 32'h04, 32'h04, "ready flag");
        chk("irq masked", 32'(irq), 32'h0);
        wr(`NGEIU_IEN_OFS, 32'h24);
        repeat (2) @(posedge clk);
        chk("irq global", 32'(irq), 32'h1);
        wr(`NGEIU_IFLAG_OFS, 32'h04);
        $display("test ecc done");
        card_in <= 1'b1;
        lock_sw <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk(`NGEIU_IFLAG_OFS, 32'h10, 32'h0, "toggle off");
        wr(`NGEIU_DEVCFG_OFS, 32'h0000_0410);
        card_in <= 1'b0;
        repeat (6) @(posedge clk);
        rdchk(`NGEIU_IFLAG_OFS, 32'h10, 32'h10, "toggle out");
        rdchk(`NGEIU_STAT_OFS, 32'h02, 32'h02, "detect out");
        wr(`NGEIU_IFLAG_OFS, 32'h10);
        card_in <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk(`NGEIU_IFLAG_OFS, 32'h10, 32'h10, "toggle in");
        rdchk(`NGEIU_STAT_OFS, 32'h06, 32'h00, "detect lock");
        $display("test card done");
        test_done;
    end
endmodule
`default_nettype wire
